// file: verilog/wdg_watchdog.sv
// Main watchdog and deep-sleep watchdog, top level.
// How it works
// - Main watchdog counts low-power RC ticks; enabling it turns that oscillator on.
// - Prescale select bit picks division by 32 or by 128.
// - Nominal prescaler period is about 1 ms or about 4 ms.
// - Four-bit postscale field further divides prescaler output, sixteen ratios.
// - Device reset and completed clock switch restart counter, prescaler and postscaler.
// - Entering and leaving sleep or idle restarts the whole watchdog chain.
// - Clear instruction restarts the counter and clears prescaler and postscaler.
// - Watchdog keeps counting in sleep or idle; expiry there wakes, not resets.
// - Time-out flag stays set until software clears it.
// - In windowed mode a clear is accepted only in the final quarter.
// - In windowed mode an early clear causes a watchdog reset.
// - Window disable bit at zero selects windowed mode.
// - Hardware enable bit set keeps watchdog running; software cannot stop it.
// - With hardware enable zero, software enable bit alone runs the watchdog.
// - Software enable bit is cleared on every device reset.
// - Deep-sleep watchdog runs in deep sleep, clocked from selected oscillator.
// - Four-bit deep-sleep postscale field sets its period.
// - Enabling deep-sleep watchdog enables its clock; expiry wakes from deep sleep.
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog
  import wdg_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Oscillator tick strobes
  input  wire logic                   low_power_rc_osc_tick,
  input  wire logic                   secondary_osc_tick,
  // Main watchdog configuration
  input  wire logic                   hw_watchdog_enable,
  input  wire logic                   prescale_select_bit,
  input  wire logic [POSTSCALE_W-1:0] postscale_select_field,
  input  wire logic                   window_disable_bit,
  // Deep-sleep watchdog configuration
  input  wire logic                   deep_sleep_watchdog_enable,
  input  wire logic                   deep_sleep_clock_select,
  input  wire logic [POSTSCALE_W-1:0] deep_sleep_postscale_field,
  // Processor events and states
  input  wire logic                   device_reset,
  input  wire logic                   clock_switch_done,
  input  wire logic                   power_save_enter,
  input  wire logic                   power_save_exit,
  input  wire logic                   in_power_save,
  input  wire logic                   in_deep_sleep,
  input  wire logic                   watchdog_clear_instruction,
  // Software access to control bits
  input  wire logic                   sw_enable_write,
  input  wire logic                   sw_enable_wdata,
  input  wire logic                   timeout_flag_clear,
  // Oscillator requests
  output logic                        low_power_rc_osc_en,
  output logic                        secondary_osc_en,
  // Results
  output logic                        watchdog_reset,
  output logic                        watchdog_wake,
  output logic                        deep_sleep_wake,
  output logic                        timeout_flag,
  output logic                        sw_watchdog_enable,
  output logic                        window_open
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (MAIN_CNT_W < PRESCALE_LOG2_128 + 15)
  begin : g_bad_main_width
    $error("main counter too narrow for longest time-out");
  end
  if (DS_CNT_W < DS_BASE_LOG2 + 15 * (1 << DS_STEP_LOG2) / 2)
  begin : g_bad_ds_width
    $error("deep sleep counter too narrow for longest time-out");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                  sw_enable_reg;
  logic                  flag_reg;
  logic                  reset_reg;
  logic                  wake_reg;
  logic                  ds_wake_reg;
  logic                  low_power_rc_osc_en_reg;
  logic                  secondary_osc_en_reg;
  logic                  main_run;
  logic                  windowed;
  logic                  main_restart;
  logic                  early_clear;
  logic                  main_expire;
  logic                  main_last_quarter;
  logic [MAIN_CNT_W-1:0] main_count;
  logic [SHIFT_W-1:0]    main_shift;
  logic                  ds_run;
  logic                  ds_tick;
  logic                  ds_expire;
  logic [SHIFT_W-1:0]    ds_shift;
  logic                  reset_next;
  logic                  flag_set;

  // ---------------------------------------------------------------
  // Enable and mode decode
  // ---------------------------------------------------------------
  assign main_run   = hw_watchdog_enable || sw_enable_reg;
  assign windowed   = !window_disable_bit;
  assign main_shift = wdg_main_shift(prescale_select_bit,
                                     postscale_select_field);

  assign early_clear = main_run && windowed && watchdog_clear_instruction
                       && !main_last_quarter;

  assign main_restart = device_reset || clock_switch_done
                        || power_save_enter || power_save_exit
                        || watchdog_clear_instruction;

  // ---------------------------------------------------------------
  // Software enable bit
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_enable_reg <= 1'b0;
    else if (device_reset)
      sw_enable_reg <= 1'b0;
    else if (sw_enable_write)
      sw_enable_reg <= sw_enable_wdata;
  end

  // ---------------------------------------------------------------
  // Main watchdog counter
  // ---------------------------------------------------------------
  wdg_tick_counter #(
    .CNT_W           (MAIN_CNT_W)
  ) u_main_cnt (
    .clk             (clk),
    .rst_n           (rst_n),
    .tick            (low_power_rc_osc_tick),
    .run             (main_run),
    .restart         (main_restart),
    .shift           (main_shift),
    .expire          (main_expire),
    .in_last_quarter (main_last_quarter),
    .count           (main_count)
  );

  // ---------------------------------------------------------------
  // Reset, wake and time-out flag
  // ---------------------------------------------------------------
  assign reset_next = (main_expire && !in_power_save) || early_clear;
  assign flag_set   = main_expire || early_clear;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_reg <= 1'b0;
      wake_reg  <= 1'b0;
    end
    else
    begin
      reset_reg <= reset_next;
      wake_reg  <= main_expire && in_power_save;
    end
  end

  // A new time-out in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_set || (flag_reg && !timeout_flag_clear);
  end

  // ---------------------------------------------------------------
  // Deep-sleep watchdog
  // ---------------------------------------------------------------
  assign ds_run   = deep_sleep_watchdog_enable && in_deep_sleep;
  assign ds_tick  = deep_sleep_clock_select ? low_power_rc_osc_tick : secondary_osc_tick;
  assign ds_shift = wdg_ds_shift(deep_sleep_postscale_field);

  wdg_tick_counter #(
    .CNT_W           (DS_CNT_W)
  ) u_ds_cnt (
    .clk             (clk),
    .rst_n           (rst_n),
    .tick            (ds_tick),
    .run             (ds_run),
    .restart         (1'b0),
    .shift           (ds_shift),
    .expire          (ds_expire),
    .in_last_quarter (),
    .count           ()
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ds_wake_reg <= 1'b0;
    else
      ds_wake_reg <= ds_expire;
  end

  // ---------------------------------------------------------------
  // Oscillator requests
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_power_rc_osc_en_reg <= 1'b0;
      secondary_osc_en_reg <= 1'b0;
    end
    else
    begin
      low_power_rc_osc_en_reg <= main_run
                     || (deep_sleep_watchdog_enable && deep_sleep_clock_select);
      secondary_osc_en_reg <= deep_sleep_watchdog_enable && !deep_sleep_clock_select;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign low_power_rc_osc_en = low_power_rc_osc_en_reg;
  assign secondary_osc_en    = secondary_osc_en_reg;
  assign watchdog_reset      = reset_reg;
  assign watchdog_wake       = wake_reg;
  assign deep_sleep_wake     = ds_wake_reg;
  assign timeout_flag        = flag_reg;
  assign sw_watchdog_enable  = sw_enable_reg;
  assign window_open         = main_run && (window_disable_bit || main_last_quarter);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_early_clear;
    main_run && windowed && watchdog_clear_instruction && !main_last_quarter;
  endsequence

  sequence s_late_clear;
    main_run && windowed && watchdog_clear_instruction && main_last_quarter
    && !main_expire && !in_power_save;
  endsequence

  a_osc_on_enable: assert property (main_run |=> low_power_rc_osc_en)
    else $error("oscillator not requested while watchdog runs");

  a_expiry_resets: assert property (main_expire && !in_power_save
                                    |=> watchdog_reset && !watchdog_wake && timeout_flag)
    else $error("expiry in run did not reset");

  a_expiry_wakes: assert property (main_expire && in_power_save
                                   |=> watchdog_wake && !watchdog_reset)
    else $error("expiry in power save did not wake");

  a_flag_holds: assert property (timeout_flag && !timeout_flag_clear
                                 |=> timeout_flag)
    else $error("time-out flag dropped without clear");

  a_flag_clears: assert property (timeout_flag_clear && !main_expire && !early_clear
                                  |=> !timeout_flag)
    else $error("time-out flag did not clear");

  a_late_clear_ok: assert property (s_late_clear |=> !watchdog_reset && main_count == '0)
    else $error("late clear not accepted");

  a_early_clear_rst: assert property (s_early_clear |=> watchdog_reset ##1 !watchdog_reset)
    else $error("early clear did not reset");

  a_hw_enable_run: assert property (hw_watchdog_enable && sw_enable_write && !sw_enable_wdata
                                    |=> main_run)
    else $error("software stopped a hardware-enabled watchdog");

  a_sw_disable_off: assert property (!hw_watchdog_enable && !sw_watchdog_enable
                                     |-> !main_run ##1 main_count == '0)
    else $error("watchdog ran while disabled");

  a_restart_events: assert property (device_reset || clock_switch_done
                                     || power_save_enter || power_save_exit
                                     |=> main_count == '0)
    else $error("restart event did not clear counter");

  a_sw_en_cleared: assert property (device_reset |=> !sw_watchdog_enable)
    else $error("software enable survived device reset");

  a_ds_wake: assert property (ds_expire |=> deep_sleep_wake ##1 !deep_sleep_wake)
    else $error("deep sleep expiry did not wake");

endmodule : wdg_watchdog
`default_nettype wire

// file: verilog/wdg_pkg.sv
// Constants and helper functions shared by the watchdog block.
package wdg_pkg;

  // ---------------------------------------------------------------
  // Clock source figures
  // ---------------------------------------------------------------
  localparam int LOW_POWER_RC_OSC_FREQ_HZ      = 31000;
  localparam int PRESCALE_LOG2_32  = 5;
  localparam int PRESCALE_LOG2_128 = 7;
  localparam int POSTSCALE_W       = 4;

  // ---------------------------------------------------------------
  // Counter sizing
  // ---------------------------------------------------------------
  localparam int SHIFT_W           = 6;
  localparam int MAIN_CNT_W        = 22;
  localparam int DS_CNT_W          = 36;
  localparam int DS_BASE_LOG2      = 6;
  localparam int DS_STEP_LOG2      = 2;

  // ---------------------------------------------------------------
  // Shift decoding
  // ---------------------------------------------------------------
  // Total main time-out in clock-source ticks is 2**shift.
  function automatic logic [SHIFT_W-1:0] wdg_main_shift(input logic psa_128,
                                                        input logic [POSTSCALE_W-1:0] post);
    logic [SHIFT_W-1:0] pre;
    pre = psa_128 ? SHIFT_W'(PRESCALE_LOG2_128) : SHIFT_W'(PRESCALE_LOG2_32);
    wdg_main_shift = pre + SHIFT_W'(post);
  endfunction : wdg_main_shift

  // Deep sleep time-out grows four times per postscale step.
  function automatic logic [SHIFT_W-1:0] wdg_ds_shift(input logic [POSTSCALE_W-1:0] post);
    wdg_ds_shift = SHIFT_W'(DS_BASE_LOG2) + (SHIFT_W'(post) << DS_STEP_LOG2'(1));
  endfunction : wdg_ds_shift

endpackage : wdg_pkg

// file: verilog/wdg_tick_counter.sv
// Power-of-two tick counter with expiry pulse and last-quarter flag.
`timescale 1ns/1ps
`default_nettype none
module wdg_tick_counter
  import wdg_pkg::*;
#(
  parameter int CNT_W = 22
)
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Control
  input  wire logic               tick,
  input  wire logic               run,
  input  wire logic               restart,
  input  wire logic [SHIFT_W-1:0] shift,
  // Status
  output logic                    expire,
  output logic                    in_last_quarter,
  output logic [CNT_W-1:0]        count
);

  // ---------------------------------------------------------------
  // Period decode
  // ---------------------------------------------------------------
  function automatic logic [CNT_W:0] span_of(input logic [SHIFT_W-1:0] s);
    span_of = {{CNT_W{1'b0}}, 1'b1} << s;
  endfunction : span_of

  logic [CNT_W:0]   span;
  logic [CNT_W-1:0] terminal;
  logic [CNT_W-1:0] threshold;
  logic [CNT_W-1:0] count_reg;
  logic             expire_reg;
  logic             at_end;

  assign span      = span_of(shift);
  assign terminal  = CNT_W'(span - 1'b1);
  assign threshold = CNT_W'(span - (span >> 2));
  assign at_end    = (count_reg == terminal);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= '0;
    else if (restart || !run)
      count_reg <= '0;
    else if (tick)
      count_reg <= at_end ? '0 : count_reg + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      expire_reg <= 1'b0;
    else
      expire_reg <= run && !restart && tick && at_end;
  end

  assign expire          = expire_reg;
  assign in_last_quarter = (count_reg >= threshold);
  assign count           = count_reg;

endmodule : wdg_tick_counter
`default_nettype wire

// file: tb/wdg_watchdog_tb_top.sv
// Self-checking bench for the main watchdog and the deep-sleep watchdog.
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog_tb_top
  import wdg_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and design instance
  // ---------------------------------------------------------------
  typedef struct {logic psa; logic [POSTSCALE_W-1:0] post; logic ps; logic hw;} wdg_row_t;
  logic                   clk, rst_n, low_power_rc_osc_tick, secondary_osc_tick;
  logic                   hw_watchdog_enable, prescale_select_bit, window_disable_bit;
  logic [POSTSCALE_W-1:0] postscale_select_field, deep_sleep_postscale_field;
  logic                   deep_sleep_watchdog_enable, deep_sleep_clock_select;
  logic                   device_reset, clock_switch_done, power_save_enter, power_save_exit;
  logic                   in_power_save, in_deep_sleep, watchdog_clear_instruction;
  logic                   sw_enable_write, sw_enable_wdata, timeout_flag_clear;
  logic                   low_power_rc_osc_en, secondary_osc_en, watchdog_reset, watchdog_wake;
  logic                   deep_sleep_wake, timeout_flag, sw_watchdog_enable, window_open;
  int                     n_mismatch, checks, n, p;
  logic                   rs, wk, dw;
  wdg_row_t               rows [6];

  wdg_watchdog wdg_watchdog_i (.clk(clk), .rst_n(rst_n), .low_power_rc_osc_tick(low_power_rc_osc_tick), .secondary_osc_tick(secondary_osc_tick),
    .hw_watchdog_enable(hw_watchdog_enable), .prescale_select_bit(prescale_select_bit),
    .postscale_select_field(postscale_select_field), .window_disable_bit(window_disable_bit),
    .deep_sleep_watchdog_enable(deep_sleep_watchdog_enable), .deep_sleep_clock_select(deep_sleep_clock_select),
    .deep_sleep_postscale_field(deep_sleep_postscale_field), .device_reset(device_reset),
    .clock_switch_done(clock_switch_done), .power_save_enter(power_save_enter),
    .power_save_exit(power_save_exit), .in_power_save(in_power_save), .in_deep_sleep(in_deep_sleep),
    .watchdog_clear_instruction(watchdog_clear_instruction), .sw_enable_write(sw_enable_write),
    .sw_enable_wdata(sw_enable_wdata), .timeout_flag_clear(timeout_flag_clear),
    .low_power_rc_osc_en(low_power_rc_osc_en), .secondary_osc_en(secondary_osc_en),
    .watchdog_reset(watchdog_reset), .watchdog_wake(watchdog_wake), .deep_sleep_wake(deep_sleep_wake),
    .timeout_flag(timeout_flag), .sw_watchdog_enable(sw_watchdog_enable), .window_open(window_open));

  always #2 clk = ~clk;

  // ---------------------------------------------------------------
  // Helper tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Pulses one processor event for one cycle: 0 reset, 1 switch, 2 enter, 3 exit, 4 clear.
  task automatic ev(input int k);
    @(negedge clk);
    device_reset = (k == 0);
    clock_switch_done = (k == 1);
    power_save_enter = (k == 2);
    power_save_exit = (k == 3);
    watchdog_clear_instruction = (k == 4);
    @(negedge clk);
    {device_reset, clock_switch_done, power_save_enter, power_save_exit, watchdog_clear_instruction} = 5'h00;
  endtask : ev

  task automatic sw_write(input logic v);
    @(negedge clk);
    sw_enable_write = 1'b1;
    sw_enable_wdata = v;
    @(negedge clk);
    sw_enable_write = 1'b0;
  endtask : sw_write

  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask : idle

  // Counts cycles until any expiry output is seen; running out of the bound ends the run.
  task automatic measure(input int lim);
    n = 0;
    {rs, wk, dw} = 3'h0;
    while (n < lim && !(rs | wk | dw))
    begin
      @(negedge clk);
      n++;
      rs = (watchdog_reset === 1'b1);
      wk = (watchdog_wake === 1'b1);
      dw = (deep_sleep_wake === 1'b1);
    end
    if (!(rs | wk | dw))
    begin
      check("expiry seen", 1'b0, 1'b1);
      final_report();
    end
  endtask : measure

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {low_power_rc_osc_tick, secondary_osc_tick, hw_watchdog_enable, prescale_select_bit, window_disable_bit} = 5'h11;
    postscale_select_field = 4'h0;
    deep_sleep_postscale_field = 4'h0;
    {deep_sleep_watchdog_enable, deep_sleep_clock_select, in_power_save, in_deep_sleep} = 4'h0;
    {device_reset, clock_switch_done, power_save_enter, power_save_exit, watchdog_clear_instruction} = 5'h00;
    {sw_enable_write, sw_enable_wdata, timeout_flag_clear} = 3'h0;
    n_mismatch = 0;
    checks = 0;
    rows = '{'{1'b0, 4'h0, 1'b0, 1'b1}, '{1'b1, 4'h0, 1'b0, 1'b1}, '{1'b0, 4'h1, 1'b1, 1'b1},
             '{1'b0, 4'h3, 1'b0, 1'b0}, '{1'b1, 4'h2, 1'b1, 1'b1}, '{1'b0, 4'h4, 1'b0, 1'b1}};
    repeat (20) @(negedge clk);
    check("outputs in reset", {low_power_rc_osc_en, secondary_osc_en, watchdog_reset, watchdog_wake,
          deep_sleep_wake, timeout_flag, sw_watchdog_enable, window_open}, 8'h00);
    rst_n = 1'b1;
    @(negedge clk);
    check("outputs after reset", {watchdog_reset, watchdog_wake, deep_sleep_wake, timeout_flag,
          sw_watchdog_enable}, 5'h00);
    // Ordinary cases: prescale, postscale, sleep or run, hardware or software enable.
    foreach (rows[i])
    begin
      hw_watchdog_enable = rows[i].hw;
      prescale_select_bit = rows[i].psa;
      postscale_select_field = rows[i].post;
      in_power_save = rows[i].ps;
      sw_write(!rows[i].hw);
      ev(4);
      check("low_power_rc_osc enable", low_power_rc_osc_en, 1'b1);
      p = 1 << ((rows[i].psa ? PRESCALE_LOG2_128 : PRESCALE_LOG2_32) + rows[i].post);
      measure(p + 8);
      check("period in range", n >= p - 1 && n <= p + 3, 1'b1);
      check("reset or wake", {rs, wk}, rows[i].ps ? 2'b01 : 2'b10);
      in_power_save = 1'b0;
      @(negedge clk);
      check("flag set", timeout_flag, 1'b1);
      idle(3);
      check("flag holds", timeout_flag, 1'b1);
      ev(0);
      check("sw enable cleared", sw_watchdog_enable, 1'b0);
      check("flag kept over device reset", timeout_flag, 1'b1);
      @(negedge clk);
      timeout_flag_clear = 1'b1;
      @(negedge clk);
      timeout_flag_clear = 1'b0;
      check("flag cleared", timeout_flag, 1'b0);
    end
    in_power_save = 1'b0;
    prescale_select_bit = 1'b0;
    postscale_select_field = 4'h0;
    // Disabled watchdog stays silent and leaves its oscillator off.
    hw_watchdog_enable = 1'b0;
    sw_write(1'b0);
    ev(4);
    for (int c = 0; c < 80; c++)
    begin
      @(negedge clk);
      if (watchdog_reset !== 1'b0 || watchdog_wake !== 1'b0)
        check("disabled quiet", 1'b1, 1'b0);
    end
    check("low_power_rc_osc off", low_power_rc_osc_en, 1'b0);
    // Every restart event in mid-count gives a full period from that event.
    hw_watchdog_enable = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      ev(4);
      idle(20);
      ev(k);
      measure(48);
      check("restart period", n >= 31 && n <= 35, 1'b1);
      timeout_flag_clear = 1'b1;
      @(negedge clk);
      timeout_flag_clear = 1'b0;
    end
    // Windowed mode: an early clear resets, a late clear restarts.
    ev(4);
    window_disable_bit = 1'b0;
    idle(2);
    check("window shut early", window_open, 1'b0);
    @(negedge clk);
    watchdog_clear_instruction = 1'b1;
    @(negedge clk);
    watchdog_clear_instruction = 1'b0;
    check("early clear resets", watchdog_reset, 1'b1);
    check("early clear flag", timeout_flag, 1'b1);
    window_disable_bit = 1'b1;
    ev(4);
    window_disable_bit = 1'b0;
    idle(25);
    check("window open late", window_open, 1'b1);
    ev(4);
    measure(48);
    check("late clear restarts", rs && n >= 31 && n <= 35, 1'b1);
    window_disable_bit = 1'b1;
    // Deep-sleep watchdog on either oscillator, two postscale settings.
    hw_watchdog_enable = 1'b0;
    deep_sleep_watchdog_enable = 1'b1;
    deep_sleep_clock_select = 1'b1;
    in_deep_sleep = 1'b1;
    measure(80);
    check("deep sleep period", dw && n >= 63 && n <= 67, 1'b1);
    in_deep_sleep = 1'b0;
    deep_sleep_clock_select = 1'b0;
    deep_sleep_postscale_field = 4'h1;
    low_power_rc_osc_tick = 1'b0;
    secondary_osc_tick = 1'b1;
    idle(2);
    check("secondary osc on", secondary_osc_en, 1'b1);
    in_deep_sleep = 1'b1;
    measure(272);
    check("deep sleep secondary_osc period", dw && n >= 255 && n <= 259, 1'b1);
    deep_sleep_watchdog_enable = 1'b0;
    in_deep_sleep = 1'b0;
    idle(3);
    check("secondary osc off", secondary_osc_en, 1'b0);
    final_report();
  end
endmodule : wdg_watchdog_tb_top
`default_nettype wire
